// >>> fetch_stage_model.sv
// behavioural fetch stage presenting instruction fields to the decoder
`timescale 1ns/10ps
module fetch_stage_model (
    // clock
    input  wire logic  core_clk,
    // instruction fields
    output logic       dec_valid,
    output logic [7:0] opcode_byte,
    output logic [7:0] addr_byte,
    output logic       has_addr_byte,
    output logic       has_dir_bit,
    output logic       has_imm_bit,
    output logic       has_width_bit,
    output logic       is_sys_mov,
    output logic [1:0] sys_class,
    output logic       uses_seg_two,
    output logic [1:0] seg_sel_two,
    output logic       op_size_32,
    output logic       addr_size_32
);
    // idle until the first instruction
    initial begin
        {dec_valid, opcode_byte, addr_byte, sys_class, seg_sel_two} = '0;
        {addr_size_32, op_size_32, uses_seg_two, is_sys_mov} = '0;
        {has_width_bit, has_imm_bit, has_dir_bit, has_addr_byte} = '0;
    end

    // one instruction per call, launched just after a falling edge, held a full cycle
    task automatic send(input logic [7:0] opc, input logic [7:0] ab, input logic [7:0] fl,
                        input logic [1:0] cls, input logic [1:0] sel);
        @(negedge core_clk);
        dec_valid = 1'b1;
        opcode_byte = opc;
        // no addressing byte: the lane carries garbage, not the last value
        addr_byte = fl[0] ? ab : ~ab;
        {addr_size_32, op_size_32, uses_seg_two, is_sys_mov} = fl[7:4];
        {has_width_bit, has_imm_bit, has_dir_bit, has_addr_byte} = fl[3:0];
        sys_class = cls;
        seg_sel_two = sel;
    endtask : send
endmodule : fetch_stage_model

// >>> operand_decode_pkg.sv
// constants and types shared by the operand field decoder
package operand_decode_pkg;

    // ****************************************
    // field positions
    // ****************************************
    localparam int FORM_HI    = 7;
    localparam int FORM_LO    = 6;
    localparam int MID_HI     = 5; // general-register / system selector field
    localparam int MID_LO     = 3;
    localparam int LOC_HI     = 2;
    localparam int LOC_LO     = 0;
    localparam int OPC_DIR    = 1; // direction and immediate-size bit
    localparam int OPC_WIDTH  = 0; // width bit

    // ****************************************
    // field codes
    // ****************************************
    localparam logic [1:0] FORM_NO_DISP  = 2'h0;
    localparam logic [1:0] FORM_DISP_SM  = 2'h1;
    localparam logic [1:0] FORM_DISP_LG  = 2'h2;
    localparam logic [1:0] FORM_REG      = 2'h3;
    localparam logic [2:0] LOC_SIB       = 3'h4;
    localparam logic [2:0] LOC_DISP32    = 3'h5;
    localparam logic [2:0] LOC_DIRECT16  = 3'h6;

    // ****************************************
    // system register classes and selectors
    // ****************************************
    localparam logic [1:0] CLS_CTL = 2'h0;
    localparam logic [1:0] CLS_DBG = 2'h1;
    localparam logic [1:0] CLS_TST = 2'h2;
    localparam logic [7:0] CTL_VALID = 8'h1D; // codes 0,2,3,4
    localparam logic [7:0] DBG_VALID = 8'hCF; // codes 0-3,6,7
    localparam logic [7:0] TST_VALID = 8'hF8; // codes 3-7

    // ****************************************
    // operand and immediate sizes in bytes
    // ****************************************
    localparam logic [2:0] SIZE_BYTE = 3'h1;
    localparam logic [2:0] SIZE_HALF = 3'h2;
    localparam logic [2:0] SIZE_FULL = 3'h4;
    localparam logic [2:0] SIZE_NONE = 3'h0;

    // ****************************************
    // segment and base selection codes
    // ****************************************
    localparam logic [1:0] SEG_EXTRA = 2'h0;
    localparam logic [1:0] SEG_CODE  = 2'h1;
    localparam logic [1:0] SEG_STACK = 2'h2;
    localparam logic [1:0] SEG_DATA  = 2'h3;

    // 16-bit address base forms
    typedef enum logic [2:0] {
        BASE_BX_SI = 3'h0,
        BASE_BX_DI = 3'h1,
        BASE_BP_SI = 3'h2,
        BASE_BP_DI = 3'h3,
        BASE_SI    = 3'h4,
        BASE_DI    = 3'h5,
        BASE_BP    = 3'h6,
        BASE_BX    = 3'h7
    } base16_e;

    // register index for stack pointer / base pointer in wide mode
    localparam logic [2:0] IDX_SP = 3'h4;
    localparam logic [2:0] IDX_BP = 3'h5;

endpackage : operand_decode_pkg

// >>> operand_field_decoder.sv
// operand field decoder: opcode bits, addressing byte and selectors
`timescale 1ns/10ps
module operand_field_decoder (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // instruction from fetch stage
    input  wire logic       dec_valid,
    input  wire logic [7:0] opcode_byte,
    input  wire logic [7:0] addr_byte,
    input  wire logic       has_addr_byte,
    input  wire logic       has_dir_bit,
    input  wire logic       has_imm_bit,
    input  wire logic       has_width_bit,
    input  wire logic       is_sys_mov,
    input  wire logic [1:0] sys_class,
    input  wire logic       uses_seg_two,
    input  wire logic [1:0] seg_sel_two,
    input  wire logic       op_size_32,
    input  wire logic       addr_size_32,
    // decoded operand fields, registered
    output logic            out_valid,
    output logic            mem_operand,
    output logic            reg_is_dest,
    output logic [2:0]      reg_index,
    output logic            reg_high_byte,
    output logic [2:0]      rm_reg_index,
    output logic            rm_high_byte,
    output logic [2:0]      operand_size,
    output logic [2:0]      imm_size,
    output logic            imm_sign_ext,
    output logic [2:0]      disp_size,
    output logic [2:0]      base16_sel,
    output logic            base_valid,
    output logic            sib_follows,
    output logic [1:0]      seg_default,
    output logic [1:0]      seg_reg,
    output logic [2:0]      sys_reg_num,
    output logic            invalid_opcode
);

    // ****************************************
    // helper functions
    // ****************************************

    // high byte register only for narrow operands with index 4 to 7
    function automatic logic high_byte(input logic [2:0] idx, input logic wide);
        high_byte = !wide && idx[2];
    endfunction : high_byte

    // bit mask lookup of a class's valid selector codes
    function automatic logic sel_ok(input logic [1:0] cls, input logic [2:0] sel);
        logic [7:0] mask;
        case (cls)
            operand_decode_pkg::CLS_CTL: mask = operand_decode_pkg::CTL_VALID;
            operand_decode_pkg::CLS_DBG: mask = operand_decode_pkg::DBG_VALID;
            operand_decode_pkg::CLS_TST: mask = operand_decode_pkg::TST_VALID;
            default:                     mask = 8'h00;
        endcase
        sel_ok = mask[sel];
    endfunction : sel_ok

    // ****************************************
    // combinational field decode
    // ****************************************
    logic [1:0] form;
    logic [2:0] mid;
    logic [2:0] loc;
    logic       wide;
    logic       dir;

    assign form = addr_byte[operand_decode_pkg::FORM_HI:operand_decode_pkg::FORM_LO];
    assign mid  = addr_byte[operand_decode_pkg::MID_HI:operand_decode_pkg::MID_LO];
    assign loc  = addr_byte[operand_decode_pkg::LOC_HI:operand_decode_pkg::LOC_LO];
    assign wide = has_width_bit ? opcode_byte[operand_decode_pkg::OPC_WIDTH] : 1'b1;
    assign dir  = opcode_byte[operand_decode_pkg::OPC_DIR];

    logic       next_out_valid;
    logic       next_mem_operand;
    logic       next_reg_is_dest;
    logic [2:0] next_reg_index;
    logic       next_reg_high_byte;
    logic [2:0] next_rm_reg_index;
    logic       next_rm_high_byte;
    logic [2:0] next_operand_size;
    logic [2:0] next_imm_size;
    logic       next_imm_sign_ext;
    logic [2:0] next_disp_size;
    logic [2:0] next_base16_sel;
    logic       next_base_valid;
    logic       next_sib_follows;
    logic [1:0] next_seg_default;
    logic [1:0] next_seg_reg;
    logic [2:0] next_sys_reg_num;
    logic       next_invalid_opcode;

    // one pass over all fields; outputs of absent fields stay at zero, the segment outputs at SEG_DATA
    always_comb begin
        next_out_valid      = dec_valid;
        next_mem_operand    = 1'b0;
        next_reg_is_dest    = 1'b0;
        next_reg_index      = 3'h0;
        next_reg_high_byte  = 1'b0;
        next_rm_reg_index   = 3'h0;
        next_rm_high_byte   = 1'b0;
        next_imm_sign_ext   = 1'b0;
        next_disp_size      = operand_decode_pkg::SIZE_NONE;
        next_base16_sel     = 3'h0;
        next_base_valid     = 1'b0;
        next_sib_follows    = 1'b0;
        next_seg_default    = operand_decode_pkg::SEG_DATA;
        next_seg_reg        = operand_decode_pkg::SEG_DATA;
        next_sys_reg_num    = 3'h0;
        next_invalid_opcode = 1'b0;

        // operand size from width bit and operation size
        if (!wide) begin
            next_operand_size = operand_decode_pkg::SIZE_BYTE;
        end else if (op_size_32) begin
            next_operand_size = operand_decode_pkg::SIZE_FULL;
        end else begin
            next_operand_size = operand_decode_pkg::SIZE_HALF;
        end

        // immediate width follows operand size unless short form is chosen
        next_imm_size = next_operand_size;
        if (has_imm_bit && dir) begin
            next_imm_size     = operand_decode_pkg::SIZE_BYTE;
            next_imm_sign_ext = wide;
        end

        // segment selector in opcode
        if (uses_seg_two) begin
            next_seg_reg = seg_sel_two;
        end

        // implicit addressing: nothing decoded from the addressing byte
        if (has_addr_byte) begin
            next_reg_is_dest = has_dir_bit && dir;
            if (is_sys_mov) begin
                next_sys_reg_num    = mid;
                next_invalid_opcode = !sel_ok(sys_class, mid);
            end else begin
                next_reg_index     = mid;
                next_reg_high_byte = high_byte(mid, wide);
            end

            if (form == operand_decode_pkg::FORM_REG) begin
                next_rm_reg_index = loc;
                next_rm_high_byte = high_byte(loc, wide);
            end else begin
                next_mem_operand = 1'b1;
                next_base_valid  = 1'b1;
                if (!addr_size_32) begin
                    next_base16_sel = loc;
                    if (form == operand_decode_pkg::FORM_DISP_SM) begin
                        next_disp_size = operand_decode_pkg::SIZE_BYTE;
                    end else if (form == operand_decode_pkg::FORM_DISP_LG) begin
                        next_disp_size = operand_decode_pkg::SIZE_HALF;
                    end else if (loc == operand_decode_pkg::LOC_DIRECT16) begin
                        next_disp_size  = operand_decode_pkg::SIZE_HALF;
                        next_base_valid = 1'b0;
                    end
                    // bp-based forms default to stack segment
                    if (next_base_valid && (loc == operand_decode_pkg::BASE_BP_SI ||
                        loc == operand_decode_pkg::BASE_BP_DI ||
                        loc == operand_decode_pkg::BASE_BP)) begin
                        next_seg_default = operand_decode_pkg::SEG_STACK;
                    end
                end else begin
                    next_rm_reg_index = loc;
                    next_sib_follows  = (loc == operand_decode_pkg::LOC_SIB);
                    if (form == operand_decode_pkg::FORM_DISP_SM) begin
                        next_disp_size = operand_decode_pkg::SIZE_BYTE;
                    end else if (form == operand_decode_pkg::FORM_DISP_LG) begin
                        next_disp_size = operand_decode_pkg::SIZE_FULL;
                    end
                    if (loc == operand_decode_pkg::LOC_DISP32) begin
                        if (form == operand_decode_pkg::FORM_NO_DISP) begin
                            next_disp_size  = operand_decode_pkg::SIZE_FULL;
                            next_base_valid = 1'b0;
                        end else begin
                            next_seg_default = operand_decode_pkg::SEG_STACK;
                        end
                    end
                end
            end
        end
        if (!uses_seg_two) begin
            next_seg_reg = next_seg_default;
        end
    end

    // ****************************************
    // output registers
    // ****************************************

    // one-cycle decode latency; outputs reset to an idle, harmless state
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            out_valid      <= 1'b0;
            mem_operand    <= 1'b0;
            reg_is_dest    <= 1'b0;
            reg_index      <= 3'h0;
            reg_high_byte  <= 1'b0;
            rm_reg_index   <= 3'h0;
            rm_high_byte   <= 1'b0;
            operand_size   <= operand_decode_pkg::SIZE_NONE;
            imm_size       <= operand_decode_pkg::SIZE_NONE;
            imm_sign_ext   <= 1'b0;
            disp_size      <= operand_decode_pkg::SIZE_NONE;
            base16_sel     <= 3'h0;
            base_valid     <= 1'b0;
            sib_follows    <= 1'b0;
            seg_default    <= operand_decode_pkg::SEG_DATA;
            seg_reg        <= operand_decode_pkg::SEG_DATA;
            sys_reg_num    <= 3'h0;
            invalid_opcode <= 1'b0;
        end else begin
            out_valid      <= next_out_valid;
            mem_operand    <= next_mem_operand;
            reg_is_dest    <= next_reg_is_dest;
            reg_index      <= next_reg_index;
            reg_high_byte  <= next_reg_high_byte;
            rm_reg_index   <= next_rm_reg_index;
            rm_high_byte   <= next_rm_high_byte;
            operand_size   <= next_operand_size;
            imm_size       <= next_imm_size;
            imm_sign_ext   <= next_imm_sign_ext;
            disp_size      <= next_disp_size;
            base16_sel     <= next_base16_sel;
            base_valid     <= next_base_valid;
            sib_follows    <= next_sib_follows;
            seg_default    <= next_seg_default;
            seg_reg        <= next_seg_reg;
            sys_reg_num    <= next_sys_reg_num;
            invalid_opcode <= next_invalid_opcode;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    sys_invalid_a: assert property (@(posedge core_clk) disable iff (rst)
        has_addr_byte && is_sys_mov && sys_class == operand_decode_pkg::CLS_CTL
        && addr_byte[5:3] == 3'h1 |=> invalid_opcode)
        else $error("control selector 001 not flagged");
    sys_valid_a: assert property (@(posedge core_clk) disable iff (rst)
        has_addr_byte && is_sys_mov && sys_class == operand_decode_pkg::CLS_TST
        && addr_byte[5:3] == 3'h3 |=> !invalid_opcode && sys_reg_num == 3'h3)
        else $error("test selector 011 rejected");
    dir_dest_a: assert property (@(posedge core_clk) disable iff (rst)
        has_addr_byte && has_dir_bit |=> reg_is_dest == $past(opcode_byte[1]))
        else $error("direction bit not followed");
    imm_short_a: assert property (@(posedge core_clk) disable iff (rst)
        has_imm_bit && opcode_byte[1] |=> imm_size == 3'h1)
        else $error("short immediate not one byte");
    implicit_form_a: assert property (@(posedge core_clk) disable iff (rst)
        !has_addr_byte |=> !mem_operand && disp_size == 3'h0 && !sib_follows)
        else $error("implicit form decoded addressing fields");
    reg_form_a: assert property (@(posedge core_clk) disable iff (rst)
        has_addr_byte && addr_byte[7:6] == 2'h3 |=> !mem_operand
        && rm_reg_index == $past(addr_byte[2:0]))
        else $error("register form took memory");
    direct_disp_a: assert property (@(posedge core_clk) disable iff (rst)
        has_addr_byte && !addr_size_32 && addr_byte[7:6] == 2'h0
        && addr_byte[2:0] == 3'h6 |=> disp_size == 3'h2 && !base_valid
        && seg_default == 2'h3)
        else $error("direct half displacement misdecoded");
    bp_byte_disp_a: assert property (@(posedge core_clk) disable iff (rst)
        has_addr_byte && addr_size_32 && addr_byte[7:6] == 2'h1
        && addr_byte[2:0] == 3'h5 |=> disp_size == 3'h1 && seg_default == 2'h2)
        else $error("base pointer byte displacement misdecoded");
    width_size_a: assert property (@(posedge core_clk) disable iff (rst)
        has_width_bit && opcode_byte[0] && op_size_32 |=> operand_size == 3'h4)
        else $error("wide 32-bit operand size wrong");
    seg_two_a: assert property (@(posedge core_clk) disable iff (rst)
        uses_seg_two |=> seg_reg == $past(seg_sel_two))
        else $error("segment selector not passed");

endmodule : operand_field_decoder

// >>> operand_field_decoder_test.sv
// self-checking bench for the operand field decoder
`timescale 1ns/10ps
module operand_field_decoder_test;
    // ****************************************
    // signals
    // ****************************************
    logic core_clk, rst, dec_valid, has_addr_byte, has_dir_bit, has_imm_bit, has_width_bit;
    logic is_sys_mov, uses_seg_two, op_size_32, addr_size_32;
    logic [7:0] opcode_byte, addr_byte;
    logic [1:0] sys_class, seg_sel_two, seg_default, seg_reg;
    logic out_valid, mem_operand, reg_is_dest, reg_high_byte, rm_high_byte, imm_sign_ext;
    logic base_valid, sib_follows, invalid_opcode;
    logic [2:0] reg_index, rm_reg_index, operand_size, imm_size, disp_size, base16_sel;
    logic [2:0] sys_reg_num;
    int err_count = 0;
    int tests_run = 0;
    // flag bits handed to the fetch model
    localparam logic [7:0] F_ADDR = 8'h01, F_DIR = 8'h02, F_IMM = 8'h04, F_W = 8'h08;
    localparam logic [7:0] F_SYS = 8'h10, F_SEG = 8'h20, F_OP32 = 8'h40, F_A32 = 8'h80;

    fetch_stage_model fm (.core_clk(core_clk), .dec_valid(dec_valid),
        .opcode_byte(opcode_byte), .addr_byte(addr_byte), .has_addr_byte(has_addr_byte),
        .has_dir_bit(has_dir_bit), .has_imm_bit(has_imm_bit), .has_width_bit(has_width_bit),
        .is_sys_mov(is_sys_mov), .sys_class(sys_class), .uses_seg_two(uses_seg_two),
        .seg_sel_two(seg_sel_two), .op_size_32(op_size_32), .addr_size_32(addr_size_32));

    operand_field_decoder dut (.core_clk(core_clk), .rst(rst), .dec_valid(dec_valid),
        .opcode_byte(opcode_byte), .addr_byte(addr_byte), .has_addr_byte(has_addr_byte),
        .has_dir_bit(has_dir_bit), .has_imm_bit(has_imm_bit), .has_width_bit(has_width_bit),
        .is_sys_mov(is_sys_mov), .sys_class(sys_class), .uses_seg_two(uses_seg_two),
        .seg_sel_two(seg_sel_two), .op_size_32(op_size_32), .addr_size_32(addr_size_32),
        .out_valid(out_valid), .mem_operand(mem_operand), .reg_is_dest(reg_is_dest),
        .reg_index(reg_index), .reg_high_byte(reg_high_byte), .rm_reg_index(rm_reg_index),
        .rm_high_byte(rm_high_byte), .operand_size(operand_size), .imm_size(imm_size),
        .imm_sign_ext(imm_sign_ext), .disp_size(disp_size), .base16_sel(base16_sel),
        .base_valid(base_valid), .sib_follows(sib_follows), .seg_default(seg_default),
        .seg_reg(seg_reg), .sys_reg_num(sys_reg_num), .invalid_opcode(invalid_opcode));

    // ****************************************
    // helpers
    // ****************************************
    // 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // launch one instruction, then look just after the edge that registers it
    task automatic step(input logic [7:0] opc, input logic [7:0] ab, input logic [7:0] fl,
                        input logic [1:0] cls, input logic [1:0] sel);
        fm.send(opc, ab, fl, cls, sel);
        @(posedge core_clk);
        #1;
        chk("out_valid", out_valid, 1'b1);
    endtask : step

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    // ****************************************
    // scenarios
    // ****************************************
    // bp plus byte displacement, register field as destination
    task automatic bp_byte_walk;
        step(8'h8B, 8'h46, F_ADDR | F_DIR | F_W, 2'h0, 2'h0);
        chk("base16_sel", base16_sel, 3'h6);
        chk("disp_size", disp_size, 3'h1);
        chk("seg_default", seg_default, 2'h2);
        chk("mem_operand", mem_operand, 1'b1);
        chk("reg_is_dest", reg_is_dest, 1'b1);
    endtask : bp_byte_walk

    // every selector of every class, back to back; class 3 never valid
    task automatic sys_selectors;
        logic [7:0] vt;
        for (int c = 0; c < 4; c++) begin
            vt = (c == 0) ? 8'h1D : (c == 1) ? 8'hCF : (c == 2) ? 8'hF8 : 8'h00;
            for (int e = 0; e < 8; e++) begin
                step(8'h22, {2'h3, e[2:0], 3'h1}, F_ADDR | F_DIR | F_SYS, c[1:0], 2'h0);
                chk("invalid_opcode", invalid_opcode, !vt[e]);
                if (vt[e]) chk("sys_reg_num", sys_reg_num, e[2:0]);
                chk("reg_index", reg_index, 3'h0);
            end
        end
    endtask : sys_selectors

    // register operands for both widths and both operation sizes
    task automatic reg_forms;
        logic       hi;
        logic [2:0] rr;
        for (int s = 0; s < 2; s++)
            for (int w = 0; w < 2; w++)
                for (int r = 0; r < 8; r++) begin
                    // inverted in three bits so the compare is not widened to ones
                    rr = ~r[2:0];
                    step({7'h44, w[0]}, {2'h3, r[2:0], rr},
                         F_ADDR | F_W | (s ? F_OP32 : 8'h00), 2'h0, 2'h0);
                    hi = (w == 0) && (r >= 4);
                    chk("mem_operand", mem_operand, 1'b0);
                    chk("reg_high_byte", reg_high_byte, hi);
                    chk("rm_high_byte", rm_high_byte, (w == 0) && (r < 4));
                    if (w || r < 4) chk("reg_index", reg_index, r[2:0]);
                    if (w || r >= 4) chk("rm_reg_index", rm_reg_index, rr);
                    chk("operand_size", operand_size, w ? (s ? 3'h4 : 3'h2) : 3'h1);
                end
    endtask : reg_forms

    // 16-bit memory forms, register field as destination
    task automatic mem16_forms;
        logic [2:0] ds;
        logic [1:0] sd;
        for (int m = 0; m < 3; m++)
            for (int r = 0; r < 8; r++) begin
                step(8'h8B, {m[1:0], 3'h2, r[2:0]}, F_ADDR | F_DIR | F_W, 2'h0, 2'h0);
                ds = (m == 1) ? 3'h1 : (m == 2 || r == 6) ? 3'h2 : 3'h0;
                sd = (r == 2 || r == 3 || (r == 6 && m != 0)) ? 2'h2 : 2'h3;
                chk("base16_sel", base16_sel, r[2:0]);
                chk("disp_size", disp_size, ds);
                chk("seg_default", seg_default, sd);
                chk("seg_reg", seg_reg, sd);
                chk("mem_operand", mem_operand, 1'b1);
                chk("base_valid", base_valid, m != 0 || r != 6);
                chk("reg_is_dest", reg_is_dest, 1'b1);
                chk("reg_index", reg_index, 3'h2);
            end
    endtask : mem16_forms

    // 32-bit memory forms, register field as source
    task automatic mem32_forms;
        logic [2:0] ds;
        for (int m = 0; m < 3; m++)
            for (int r = 0; r < 8; r++) begin
                step(8'h89, {m[1:0], 3'h3, r[2:0]},
                     F_ADDR | F_DIR | F_W | F_OP32 | F_A32, 2'h0, 2'h0);
                ds = (m == 1) ? 3'h1 : (m == 2 || r == 5) ? 3'h4 : 3'h0;
                chk("sib_follows", sib_follows, r == 4);
                chk("reg_is_dest", reg_is_dest, 1'b0);
                chk("mem_operand", mem_operand, 1'b1);
                if (r != 4) begin
                    chk("disp_size", disp_size, ds);
                    chk("seg_default", seg_default, (r == 5 && m != 0) ? 2'h2 : 2'h3);
                    chk("base_valid", base_valid, m != 0 || r != 5);
                end
                if (r != 4 && (m != 0 || r != 5)) begin
                    chk("rm_reg_index", rm_reg_index, r[2:0]);
                end
            end
    endtask : mem32_forms

    // immediate width over size bit, width bit and operation size
    task automatic imm_sizes;
        for (int k = 0; k < 8; k++) begin
            step({6'h20, k[1:0]}, 8'hC0, F_ADDR | F_IMM | F_W | (k[2] ? F_OP32 : 8'h00),
                 2'h0, 2'h0);
            chk("imm_size", imm_size, k[1] ? 3'h1 : k[0] ? (k[2] ? 3'h4 : 3'h2) : 3'h1);
            if (k[0]) chk("imm_sign_ext", imm_sign_ext, k[1]);
        end
    endtask : imm_sizes

    // two-bit segment selector, then an implicit-address instruction
    task automatic seg_and_implicit;
        for (int s = 0; s < 4; s++) begin
            step(8'h8E, 8'hC0, F_ADDR | F_DIR | F_SEG, 2'h0, s[1:0]);
            chk("seg_reg", seg_reg, s[1:0]);
        end
        step(8'h50, 8'h84, 8'h00, 2'h0, 2'h0);
        chk("mem_operand", mem_operand, 1'b0);
        chk("disp_size", disp_size, 3'h0);
        chk("sib_follows", sib_follows, 1'b0);
    endtask : seg_and_implicit

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        rst = 1'b1;
        repeat (3) @(negedge core_clk);
        chk("out_valid", out_valid, 1'b0);
        chk("seg_default", seg_default, 2'h3);
        rst = 1'b0;
        bp_byte_walk();
        sys_selectors();
        reg_forms();
        mem16_forms();
        mem32_forms();
        imm_sizes();
        seg_and_implicit();
        wrap_up();
    end

    // cut a hang short
    initial begin
        repeat (5000) @(posedge core_clk);
        err_count++;
        wrap_up();
    end
endmodule : operand_field_decoder_test
